/* mdm_regs.vh */
// Constants for the motor delay manager: widths, reset values, encodings.
// Assumes inclusion by bare name; definitions only.
`ifndef MDM_REGS_VH
`define MDM_REGS_VH

`define MDM_W            8
`define MDM_PRE_W        4
`define MDM_TIMER_RST    8'h00
`define MDM_TIMER_MID    8'h80
`define MDM_TIMER_MAX    8'hFF
`define MDM_SPEEDUP_LIM  8'h55
`define MDM_PRE_RST      4'h0
`define MDM_PRE_MAX      4'hF
`define MDM_PRE_MIN      4'h0
`define MDM_TES_NONE     2'h0
`define MDM_MODE_SWITCH  1'b0
`define MDM_MODE_AUTO    1'b1
`define MDM_MUL_SHIFT    8

`endif

/* mdm_tick_gen.v */
// Prescaled tick source for the step timer.
// Assumes one clock domain; ratio is a power-of-two exponent.
`timescale 1ns/1ps
module mdm_tick_gen (
   // Clock and reset
   input  wire       clk,
   input  wire       srst,
   // Control
   input  wire       run,
   input  wire [3:0] ratio,
   // Tick out
   output reg        tick_q
);
   reg [15:0] div_q;
   wire [15:0] div_nx = div_q + 16'h0001;
   wire [15:0] lim = (16'h0001 << ratio) - 16'h0001;

   always @(posedge clk) begin
      if (srst) begin
         div_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else if (!run) begin
         div_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else if (div_q >= lim) begin
         div_q  <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_nx;
         tick_q <= 1'b0;
      end
   end
endmodule

/* mdm_delay_manager.v */
// Motor delay manager: step timer, prescaler, capture and compare regs.
// Assumes zero-cross and demag event strobes come from same-clock logic.
`timescale 1ns/1ps
`include "mdm_regs.vh"
module mdm_delay_manager (
   // Clock and reset
   input  wire       clk,
   input  wire       srst,
   // Configuration
   input  wire       timer_clock_enable,
   input  wire       auto_commutation_select,
   input  wire       soft_commutation_enable,
   input  wire       delay_from_latest,
   input  wire [1:0] tacho_edge_select,
   input  wire [7:0] weight,
   // Software writes
   input  wire       compare_wr,
   input  wire [7:0] compare_wdata,
   input  wire       ratio_wr,
   input  wire [3:0] ratio_wdata,
   input  wire       request_wr,
   input  wire       request_inc_wdata,
   input  wire       request_dec_wdata,
   input  wire       flag_clr,
   input  wire       overflow_clr,
   input  wire       commutation_irq_mask,
   input  wire       preload_in,
   // Events
   input  wire       zero_cross_event,
   input  wire       demag_event,
   // Status
   output reg  [7:0] step_timer_q,
   output reg  [7:0] commutation_compare_q,
   output reg  [7:0] zero_cross_latest_q,
   output reg  [7:0] zero_cross_previous_q,
   output reg  [7:0] demag_capture_compare_q,
   output reg  [3:0] step_ratio_field_q,
   output reg        ratio_increment_request_q,
   output reg        ratio_decrement_request_q,
   output reg        commutation_irq_flag_q,
   output reg        timer_overflow_flag_q,
   output reg        irq_q,
   output reg        commutation_pulse_q,
   output reg        preload_active_q,
   output reg        ratio_write_refused_q,
   output reg        six_step_allowed_q
);
   // ----------------------------------------------------------------
   // Tick source
   // ----------------------------------------------------------------
   wire tick;
   mdm_tick_gen u_tick (
      .clk    (clk),
      .srst   (srst),
      .run    (timer_clock_enable),
      .ratio  (step_ratio_field_q),
      .tick_q (tick)
   );

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   reg         armed_q;
   wire        auto_md  = (auto_commutation_select == `MDM_MODE_AUTO);
   wire        speed_md = (tacho_edge_select != `MDM_TES_NONE);
   wire        tes_none = ~speed_md;
   wire        at_max   = (step_timer_q == `MDM_TIMER_MAX);
   // Soft compare needs a write before it is honoured
   wire        cmp_ok   = soft_commutation_enable ? armed_q : 1'b1;
   wire        cmp_hit  = cmp_ok && tick && !speed_md &&
                          (step_timer_q + 8'h01 >= commutation_compare_q) &&
                          (auto_md || step_timer_q + 8'h01 ==
                                      commutation_compare_q);
   wire        zc_auto  = zero_cross_event && auto_md && !speed_md;
   wire        can_inc  = (step_ratio_field_q != `MDM_PRE_MAX);
   wire        can_dec  = (step_ratio_field_q != `MDM_PRE_MIN);
   wire        ap_inc   = cmp_hit && !auto_md && ratio_increment_request_q
                          && can_inc;
   wire        ap_dec   = cmp_hit && !auto_md && ratio_decrement_request_q
                          && can_dec;
   // Autoswitched overflow slows the prescaler, fast zero-cross speeds it
   wire        au_inc   = auto_md && tick && at_max && can_inc && !speed_md;
   wire        au_dec   = zc_auto && (step_timer_q < `MDM_SPEEDUP_LIM)
                          && can_dec;
   wire        sh_r     = ap_inc || au_inc;
   wire        sh_l     = ap_dec || au_dec;
   // Multiplier sees the values this zero-cross captures, so the next
   // commutation tracks the step just measured, or with delay_from_latest clear the one before it
   wire [7:0]  zc_cap   = sh_l ? {step_timer_q[6:0], 1'b0}
                               : step_timer_q;
   wire [7:0]  zc_prv   = sh_l ? {zero_cross_latest_q[6:0], 1'b0}
                               : zero_cross_latest_q;
   wire [7:0]  mul_src  = delay_from_latest ? zc_cap : zc_prv;
   wire [15:0] mul_full = weight * mul_src;
   wire [7:0]  mul_res  = mul_full[15:`MDM_MUL_SHIFT];

   // ----------------------------------------------------------------
   // Step timer and captures
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         step_timer_q          <= `MDM_TIMER_RST;
         zero_cross_latest_q   <= `MDM_TIMER_RST;
         zero_cross_previous_q <= `MDM_TIMER_RST;
         demag_capture_compare_q <= `MDM_TIMER_RST;
         timer_overflow_flag_q <= 1'b0;
      end else begin
         if (zc_auto) begin
            // Cascade captures, timer restarts
            zero_cross_latest_q   <= sh_l ? {step_timer_q[6:0], 1'b0}
                                          : step_timer_q;
            zero_cross_previous_q <= sh_l ? {zero_cross_latest_q[6:0], 1'b0}
                                          : zero_cross_latest_q;
            step_timer_q <= `MDM_TIMER_RST;
         end else if (cmp_hit && !auto_md) begin
            step_timer_q <= `MDM_TIMER_RST;
         end else if (tick) begin
            if (at_max)
               step_timer_q <= au_inc ? `MDM_TIMER_MID
                                      : `MDM_TIMER_RST;
            else
               step_timer_q <= step_timer_q + 8'h01;
         end
         if (!zc_auto && sh_r) begin
            zero_cross_latest_q   <= {1'b0, zero_cross_latest_q[7:1]};
            zero_cross_previous_q <= {1'b0, zero_cross_previous_q[7:1]};
         end else if (!zc_auto && sh_l) begin
            zero_cross_latest_q   <= {zero_cross_latest_q[6:0], 1'b0};
            zero_cross_previous_q <= {zero_cross_previous_q[6:0], 1'b0};
         end
         // Demag events only capture, never touch the timer
         if (demag_event)
            demag_capture_compare_q <= step_timer_q;
         else if (sh_r)
            demag_capture_compare_q <= {1'b0, demag_capture_compare_q[7:1]};
         else if (sh_l)
            demag_capture_compare_q <= {demag_capture_compare_q[6:0], 1'b0};
         // Set wins over clear
         if (tick && at_max && tes_none)
            timer_overflow_flag_q <= 1'b1;
         else if (overflow_clr)
            timer_overflow_flag_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Compare register and arming
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         commutation_compare_q <= `MDM_TIMER_MAX;
         armed_q               <= 1'b0;
      end else begin
         if (compare_wr) begin
            commutation_compare_q <= compare_wdata;   // any value, zero included
            armed_q               <= 1'b1;
         end else if (zc_auto && !soft_commutation_enable) begin
            commutation_compare_q <= mul_res;
            armed_q               <= 1'b0;
         end else begin
            // Any write arms the compare; a hit or soft mode being off disarms it
            if (cmp_hit || !soft_commutation_enable)
               armed_q <= 1'b0;
            if (sh_r)
               commutation_compare_q <=
                  {1'b0, commutation_compare_q[7:1]};
            else if (sh_l)
               commutation_compare_q <=
                  {commutation_compare_q[6:0], 1'b0};
         end
      end
   end

   // ----------------------------------------------------------------
   // Prescaler and requests
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         step_ratio_field_q        <= `MDM_PRE_RST;
         ratio_increment_request_q <= 1'b0;
         ratio_decrement_request_q <= 1'b0;
         ratio_write_refused_q     <= 1'b0;
      end else begin
         ratio_write_refused_q <= ratio_wr && timer_clock_enable;
         if (ratio_wr && !timer_clock_enable)
            step_ratio_field_q <= ratio_wdata;
         else if (sh_r)
            step_ratio_field_q <= step_ratio_field_q + 4'h1;
         else if (sh_l)
            step_ratio_field_q <= step_ratio_field_q - 4'h1;
         else if (speed_md && zero_cross_event && timer_clock_enable) begin
            // Speed mode adapts the ratio from the live step timer at each zero-cross while the timer clock runs
            if (step_timer_q == `MDM_TIMER_MAX && can_inc)
               step_ratio_field_q <= step_ratio_field_q + 4'h1;
            else if (step_timer_q < `MDM_SPEEDUP_LIM && can_dec)
               step_ratio_field_q <= step_ratio_field_q - 4'h1;
         end
         if (request_wr && !(request_inc_wdata && request_dec_wdata)) begin
            // Software write of both bits is ignored
            ratio_increment_request_q <= request_inc_wdata;
            ratio_decrement_request_q <= request_dec_wdata;
         end else begin
            if (cmp_hit && !auto_md && ratio_increment_request_q)
               ratio_increment_request_q <= 1'b0;
            if (cmp_hit && !auto_md && ratio_decrement_request_q)
               ratio_decrement_request_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Commutation flag, preload, interrupt
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (srst) begin
         commutation_irq_flag_q <= 1'b0;
         irq_q                  <= 1'b0;
         commutation_pulse_q    <= 1'b0;
         preload_active_q       <= 1'b0;
         six_step_allowed_q     <= 1'b0;
      end else begin
         commutation_pulse_q <= cmp_hit;
         six_step_allowed_q  <= tes_none;
         if (cmp_hit)
            preload_active_q <= preload_in;
         if (cmp_hit)
            commutation_irq_flag_q <= 1'b1;
         else if (flag_clr)
            commutation_irq_flag_q <= 1'b0;
         irq_q <= (commutation_irq_flag_q || cmp_hit)
                  && commutation_irq_mask;
      end
   end
endmodule

/* mdm_delay_manager_properties.sv */
// Port-level checker for the motor delay manager.
// Assumes one clock and a synchronous high reset; bound below.
`timescale 1ns/1ps
module mdm_chk (
   // Clock and reset
   input wire       clk,
   input wire       srst,
   // Inputs watched
   input wire       timer_clock_enable,
   input wire       auto_commutation_select,
   input wire [1:0] tacho_edge_select,
   input wire       ratio_wr,
   input wire [3:0] ratio_wdata,
   input wire       request_wr,
   input wire       request_inc_wdata,
   input wire       request_dec_wdata,
   input wire       commutation_irq_mask,
   // Outputs watched
   input wire [7:0] step_timer_q,
   input wire [3:0] step_ratio_field_q,
   input wire       ratio_increment_request_q,
   input wire       ratio_decrement_request_q,
   input wire       commutation_irq_flag_q,
   input wire       timer_overflow_flag_q,
   input wire       irq_q,
   input wire       commutation_pulse_q,
   input wire       ratio_write_refused_q,
   input wire       six_step_allowed_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   a_refuse_ratio: assert property (ratio_wr && timer_clock_enable
      |=> ratio_write_refused_q) else $error("ratio write not refused");
   a_refuse_cause: assert property (ratio_write_refused_q
      |-> $past(ratio_wr) && $past(timer_clock_enable))
      else $error("spurious refusal");
   a_ratio_write: assert property (ratio_wr && !timer_clock_enable
      |=> step_ratio_field_q == $past(ratio_wdata))
      else $error("ratio write lost");
   // Only from idle: a pending request must survive, checked in bench
   a_both_req: assert property (request_wr && request_inc_wdata
      && request_dec_wdata && !ratio_increment_request_q
      && !ratio_decrement_request_q |=> !ratio_increment_request_q
      && !ratio_decrement_request_q) else $error("double request taken");
   a_pulse_flag: assert property (commutation_pulse_q
      |-> commutation_irq_flag_q) else $error("flag missing");
   a_irq_mask: assert property ($rose(commutation_irq_flag_q)
      && commutation_irq_mask |-> ##[0:1] irq_q) else $error("no irq");
   a_comm_clear: assert property (commutation_pulse_q
      && !auto_commutation_select |-> step_timer_q <= 8'h01)
      else $error("timer not cleared");
   // No hit can clear the timer once the clock has been off a cycle, as tick is then low
   a_timer_hold: assert property (!timer_clock_enable
      && $past(timer_clock_enable) == 1'b0 && !auto_commutation_select
      |=> $stable(step_timer_q) || step_timer_q == 8'h00)
      else $error("timer moved while stopped");
   a_ovf_flag: assert property ($rose(timer_overflow_flag_q)
      |-> $past(tacho_edge_select) == 2'h0) else $error("bad overflow");
   a_six_step: assert property (tacho_edge_select != 2'h0
      |=> !six_step_allowed_q) else $error("six-step in speed mode");
   c_pulse: cover property (commutation_pulse_q);
   c_refused: cover property (ratio_write_refused_q);
   c_overflow: cover property ($rose(timer_overflow_flag_q));
   c_auto_hit: cover property (commutation_pulse_q
      && auto_commutation_select);
endmodule

bind mdm_delay_manager mdm_chk u_chk (.*);

/* mdm_delay_manager_tb.sv */
// Self-checking bench for the motor delay manager.
// Assumes only the clock paces events; inputs move on falling edges.
`timescale 1ns/1ps
module mdm_delay_manager_tb;
   reg        clk, srst, timer_clock_enable, auto_commutation_select;
   reg        soft_commutation_enable, delay_from_latest, compare_wr;
   reg        ratio_wr, request_wr, request_inc_wdata, request_dec_wdata;
   reg        flag_clr, overflow_clr, commutation_irq_mask, preload_in;
   reg        zero_cross_event, demag_event, hit;
   reg  [1:0] tacho_edge_select;
   reg  [7:0] weight, compare_wdata, t;
   reg  [3:0] ratio_wdata;
   wire [7:0] step_timer_q, commutation_compare_q, zero_cross_latest_q;
   wire [7:0] zero_cross_previous_q, demag_capture_compare_q;
   wire [3:0] step_ratio_field_q;
   wire       ratio_increment_request_q, ratio_decrement_request_q;
   wire       commutation_irq_flag_q, timer_overflow_flag_q, irq_q;
   wire       commutation_pulse_q, preload_active_q, ratio_write_refused_q;
   wire       six_step_allowed_q;
   integer    error_cnt, n_compared, i;

   mdm_delay_manager u_dut (.*);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task check(input [7:0] seen, input [7:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   // Strobe k for one cycle: compare, ratio, request, flag clear,
   // overflow clear, zero-cross, demag
   task op(input integer k, input [7:0] v);
      begin
         compare_wdata = v;
         ratio_wdata = v[3:0];
         request_inc_wdata = v[0];
         request_dec_wdata = v[1];
         {demag_event, zero_cross_event, overflow_clr, flag_clr, request_wr,
          ratio_wr, compare_wr} = 7'h01 << k;
         @(negedge clk);
         {demag_event, zero_cross_event, overflow_clr, flag_clr, request_wr,
          ratio_wr, compare_wr} = 7'h00;
      end
   endtask
   task wait_hit(input integer n);
      begin
         hit = 1'b0;
         for (i = 0; i < n && !hit; i = i + 1) begin
            @(negedge clk);
            hit = (commutation_pulse_q === 1'b1);
         end
      end
   endtask
   task test_done;
      begin
         $display("compared %0d mismatches %0d", n_compared, error_cnt);
         if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      {timer_clock_enable, auto_commutation_select, soft_commutation_enable,
       delay_from_latest, compare_wr, ratio_wr, request_wr,
       request_inc_wdata, request_dec_wdata, flag_clr, overflow_clr,
       commutation_irq_mask, preload_in, zero_cross_event,
       demag_event} = 15'h0000;
      tacho_edge_select = 2'h0;
      weight = 8'h40;
      compare_wdata = 8'h00;
      ratio_wdata = 4'h0;
      error_cnt = 0;
      n_compared = 0;
      srst = 1'b1;
      repeat (4) @(negedge clk);
      srst = 1'b0;
      check(commutation_compare_q, 8'hFF);
      check(step_timer_q, 8'h00);
      op(1, 8'h02);
      check(step_ratio_field_q, 8'h02);
      timer_clock_enable = 1'b1;
      op(1, 8'h05);
      check(ratio_write_refused_q, 1'b1);
      check(step_ratio_field_q, 8'h02);
      timer_clock_enable = 1'b0;
      wait_hit(3);
      op(1, 8'h00);
      timer_clock_enable = 1'b1;
      wait_hit(10);
      timer_clock_enable = 1'b0;
      wait_hit(2);
      t = step_timer_q;
      op(5, 8'h00);
      op(6, 8'h00);
      wait_hit(2);
      check(step_timer_q, t);
      check(demag_capture_compare_q, t);
      check(t, 8'h0A);
      op(2, 8'h03);
      check(ratio_increment_request_q, 1'b0);
      check(ratio_decrement_request_q, 1'b0);
      $display("test ratio access done");
      preload_in = 1'b1;
      commutation_irq_mask = 1'b1;
      op(0, 8'h03);
      timer_clock_enable = 1'b1;
      wait_hit(600);
      check(hit, 1'b1);
      check(commutation_irq_flag_q, 1'b1);
      check(preload_active_q, 1'b1);
      timer_clock_enable = 1'b0;
      wait_hit(1);
      check(irq_q, 1'b1);
      op(3, 8'h00);
      check(commutation_irq_flag_q, 1'b0);
      op(2, 8'h01);
      op(2, 8'h03);
      check(ratio_increment_request_q, 1'b1);
      timer_clock_enable = 1'b1;
      wait_hit(600);
      check(step_ratio_field_q, 8'h01);
      check(commutation_compare_q, 8'h01);
      check(ratio_increment_request_q, 1'b0);
      timer_clock_enable = 1'b0;
      op(2, 8'h02);
      timer_clock_enable = 1'b1;
      wait_hit(600);
      check(step_ratio_field_q, 8'h00);
      check(commutation_compare_q, 8'h02);
      check(ratio_decrement_request_q, 1'b0);
      $display("test commutation done");
      soft_commutation_enable = 1'b1;
      op(4, 8'h00);
      check(timer_overflow_flag_q, 1'b0);
      wait_hit(300);
      check(hit, 1'b0);
      check(timer_overflow_flag_q, 1'b1);
      op(0, 8'h10);
      wait_hit(600);
      check(hit, 1'b1);
      op(4, 8'h00);
      tacho_edge_select = 2'h1;
      wait_hit(300);
      check(timer_overflow_flag_q, 1'b0);
      check(six_step_allowed_q, 1'b0);
      $display("test overflow done");
      timer_clock_enable = 1'b0;
      repeat (2) @(negedge clk);
      tacho_edge_select = 2'h0;
      soft_commutation_enable = 1'b0;
      auto_commutation_select = 1'b1;
      weight = 8'h80;
      delay_from_latest = 1'b1;
      op(5, 8'h00);
      timer_clock_enable = 1'b1;
      repeat (8) @(negedge clk);
      timer_clock_enable = 1'b0;
      repeat (2) @(negedge clk);
      op(5, 8'h00);
      check(zero_cross_latest_q, 8'h08);
      check(step_timer_q, 8'h00);
      check(commutation_compare_q, 8'h04);
      timer_clock_enable = 1'b1;
      repeat (6) @(negedge clk);
      timer_clock_enable = 1'b0;
      repeat (2) @(negedge clk);
      op(5, 8'h00);
      check(zero_cross_previous_q, 8'h08);
      check(zero_cross_latest_q, 8'h06);
      check(commutation_compare_q, 8'h03);
      timer_clock_enable = 1'b1;
      wait_hit(20);
      check(hit, 1'b1);
      check(step_timer_q, 8'h03);
      $display("test autoswitch done");
      test_done;
   end

   initial begin
      #200000;
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      test_done;
   end
endmodule
